// >>> common/fwpe_defines.vh
// Instruction codes, timing figures and protection constants for the flash protect core
`ifndef FWPE_DEFINES_VH
`define FWPE_DEFINES_VH

`define FWPE_CLK_MHZ       100
`define FWPE_OP_WRITE_ENABLE_INSTR       8'h06
`define FWPE_OP_WRDI       8'h04
`define FWPE_OP_RDSR       8'h05
`define FWPE_OP_STATUS_WRITE_INSTR       8'h01
`define FWPE_OP_PP         8'h02
`define FWPE_OP_SE         8'h20
`define FWPE_OP_BE32       8'h52
`define FWPE_OP_BE64       8'hd8
`define FWPE_OP_CE_A       8'hc7
`define FWPE_OP_CE_B       8'h60
`define FWPE_OP_SUSP       8'h75
`define FWPE_OP_LOCK       8'h36
`define FWPE_OP_UNLOCK     8'h39
`define FWPE_OP_GLOCK      8'h7e
`define FWPE_OP_GUNLOCK    8'h98
`define FWPE_OP_DSLEEP     8'hb9
`define FWPE_OP_DWAKE      8'hab
`define FWPE_SR_WIP_BIT    0
`define FWPE_SR_WEL_BIT    1
`define FWPE_LOCK_COUNT    158
`define FWPE_EDGE_SECTORS  16
`define FWPE_SECTOR_BYTES  4096
`define FWPE_BLOCK_BYTES   65536
`define FWPE_TOP_BLOCK     24'hff0000
`define FWPE_T_W_US        5000
`define FWPE_T_PP_US       700
`define FWPE_T_SE_US       45000
`define FWPE_T_BE32_US     120000
`define FWPE_T_BE64_US     150000
`define FWPE_T_CE_US       20000000

`endif

// >>> verilog/fwpe_core.v
// Flash write protection, program/erase sequencing and power state control
`timescale 1ns/10ps
`default_nettype none
`include "fwpe_defines.vh"
// Operation
// - Complemented protect field: 000 all, 111 none, 001-110 keep 63/64 to 1/2.
// - Complemented with sector bit set: only a 4 to 32 kB end region unprotected.
// - Program or erase touching any protected part is ignored.
// - Individual locks govern only when scheme select is 1, else protect field.
// - All individual lock bits are 1 after power-up.
// - Page program takes up to 256 bytes in one page, clears bits only.
// - Erase sets sector, block or whole array to FFh in an erase cycle.
// - In-progress flag is 1 through status write, program or erase cycle.
// - Active while chip select low or an internal cycle runs, else standby.
// - Deep sleep entered by entry instruction, left only by release instruction.
// - In deep sleep every instruction but release is ignored.
// - Write-enable latch clears when program, erase or status write completes.
// - Write, program and erase need chip select to rise on a byte boundary.
// - While busy only read status and suspend are accepted.
// - Lock bit 0 allows program and erase of its region, 1 blocks them.
module fwpe_core #(
  parameter [31:0] SRW_CYCLES  = `FWPE_T_W_US * `FWPE_CLK_MHZ,
  parameter [31:0] PP_CYCLES   = `FWPE_T_PP_US * `FWPE_CLK_MHZ,
  parameter [31:0] SE_CYCLES   = `FWPE_T_SE_US * `FWPE_CLK_MHZ,
  parameter [31:0] BE32_CYCLES = `FWPE_T_BE32_US * `FWPE_CLK_MHZ,
  parameter [31:0] BE64_CYCLES = `FWPE_T_BE64_US * `FWPE_CLK_MHZ,
  parameter [31:0] CE_CYCLES   = `FWPE_T_CE_US * `FWPE_CLK_MHZ
) (
  input  wire        CLK,
  input  wire        RESET_N,
  input  wire        SCK,
  input  wire        CS_N,
  input  wire        MOSI,
  output reg         MISO,
  output reg         MISO_OE,
  input  wire        SECTOR_GRANULARITY_SEL,
  input  wire        TOP_BOTTOM_SEL,
  input  wire        PROTECT_FIELD_BIT2,
  input  wire        PROTECT_FIELD_BIT1,
  input  wire        PROTECT_FIELD_BIT0,
  input  wire        PROTECT_COMPLEMENT,
  input  wire        PROTECT_SCHEME_SEL,
  output reg         WRITE_IN_PROGRESS_FLAG,
  output reg         WRITE_ENABLE_LATCH,
  output reg         DEEP_SLEEP,
  output reg         ACTIVE,
  output reg         PROG_STROBE,
  output reg  [23:0] PROG_ADDR,
  output reg  [7:0]  PROG_DATA,
  output reg         ERASE_STROBE,
  output reg  [23:0] ERASE_FIRST,
  output reg  [23:0] ERASE_LAST,
  output reg         STATUS_WR_STROBE,
  output reg  [7:0]  STATUS_WR_DATA
);
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_PROG = 2'h1;
  localparam [1:0] ST_WAIT = 2'h2;

  // Link pins cross into CLK through two flops; the third stage only finds edges
  reg  [1:0]  sck_q;
  reg  [1:0]  cs_q;
  reg  [1:0]  mosi_q;
  reg         sck_d;
  reg         cs_d;
  wire        sck_rise    = sck_q[1] & ~sck_d;
  wire        sck_fall    = ~sck_q[1] & sck_d;
  wire        frame_start = ~cs_q[1] & cs_d;
  wire        frame_end   = cs_q[1] & ~cs_d;

  reg  [2:0]  bit_cnt;
  reg  [6:0]  shift;
  reg  [9:0]  byte_cnt;
  reg  [7:0]  opcode;
  reg  [23:0] addr;
  reg  [7:0]  sr_data;
  reg  [7:0]  col;
  reg         frame_ok;
  reg  [7:0]  page_buf [0:255];
  reg  [255:0] page_valid;
  reg  [`FWPE_LOCK_COUNT-1:0] lock;
  reg  [1:0]  state;
  reg  [31:0] cnt;
  reg  [7:0]  pcol;
  reg  [23:0] page_base;

  wire [7:0]  new_byte  = {shift, mosi_q[1]};
  wire        byte_done = sck_rise & ~cs_q[1] & (bit_cnt == 3'h7);
  wire [7:0]  status    = {6'h00, WRITE_ENABLE_LATCH, WRITE_IN_PROGRESS_FLAG};

  // Opcode acceptance at the first byte
  wire        op_ok = DEEP_SLEEP ? (new_byte == `FWPE_OP_DWAKE) :
                      WRITE_IN_PROGRESS_FLAG ? ((new_byte == `FWPE_OP_RDSR) |
                                                (new_byte == `FWPE_OP_SUSP)) :
                      1'b1;

  always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      sck_q  <= 2'h0;
      cs_q   <= 2'h3;
      mosi_q <= 2'h0;
      sck_d  <= 1'b0;
      cs_d   <= 1'b1;
    end else begin
      sck_q  <= {sck_q[0], SCK};
      cs_q   <= {cs_q[0], CS_N};
      mosi_q <= {mosi_q[0], MOSI};
      sck_d  <= sck_q[1];
      cs_d   <= cs_q[1];
    end
  end

  // Frame deserialiser
  always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      bit_cnt    <= 3'h0;
      shift      <= 7'h00;
      byte_cnt   <= 10'h000;
      opcode     <= 8'h00;
      addr       <= 24'h000000;
      sr_data    <= 8'h00;
      col        <= 8'h00;
      frame_ok   <= 1'b0;
      page_valid <= 256'h0;
    end else if (frame_start) begin
      bit_cnt  <= 3'h0;
      byte_cnt <= 10'h000;
      frame_ok <= 1'b0;
    end else if (sck_rise & ~cs_q[1]) begin
      bit_cnt <= bit_cnt + 3'h1;
      shift   <= new_byte[6:0];
      if (byte_done) begin
        if (byte_cnt != 10'h3ff)
          byte_cnt <= byte_cnt + 10'h001;
        if (byte_cnt == 10'h000) begin
          opcode   <= new_byte;
          frame_ok <= op_ok;
          if (op_ok & (new_byte == `FWPE_OP_PP))
            page_valid <= 256'h0;
        end else if (byte_cnt < 10'h004) begin
          addr <= {addr[15:0], new_byte};
          if (byte_cnt == 10'h001)
            sr_data <= new_byte;
          if (byte_cnt == 10'h003)
            col <= new_byte;
        end else if (frame_ok & (opcode == `FWPE_OP_PP)) begin
          page_valid[col] <= 1'b1;
          col <= col + 8'h01;
        end
      end
    end
  end

  // Page data; wraps inside the page as the column counter rolls over
  always @(posedge CLK) begin
    if (byte_done & frame_ok & (opcode == `FWPE_OP_PP) & (byte_cnt >= 10'h004))
      page_buf[col] <= new_byte;
  end

  // Target range of the instruction just received
  reg  [23:0] tgt_lo;
  reg  [23:0] tgt_hi;
  always @* begin
    case (opcode)
      `FWPE_OP_PP:   begin tgt_lo = {addr[23:8], 8'h00};   tgt_hi = {addr[23:8], 8'hff};   end
      `FWPE_OP_SE:   begin tgt_lo = {addr[23:12], 12'h000}; tgt_hi = {addr[23:12], 12'hfff}; end
      `FWPE_OP_BE32: begin tgt_lo = {addr[23:15], 15'h0000}; tgt_hi = {addr[23:15], 15'h7fff}; end
      `FWPE_OP_BE64: begin tgt_lo = {addr[23:16], 16'h0000}; tgt_hi = {addr[23:16], 16'hffff}; end
      default:       begin tgt_lo = 24'h000000;             tgt_hi = 24'hffffff;             end
    endcase
  end

  // Protect field map; the plain map region is the unprotected one when complemented
  wire [2:0]  bp = {PROTECT_FIELD_BIT2, PROTECT_FIELD_BIT1, PROTECT_FIELD_BIT0};
  reg  [4:0]  reg_exp;
  always @* begin
    if (SECTOR_GRANULARITY_SEL)
      reg_exp = bp[2] ? 5'd15 : (5'd11 + {2'h0, bp});
    else
      reg_exp = 5'd17 + {2'h0, bp};
  end
  wire [23:0] reg_m1   = ~(24'hffffff << reg_exp);
  wire [23:0] reg_lo   = TOP_BOTTOM_SEL ? 24'h000000 : ~reg_m1;
  wire [23:0] reg_hi   = TOP_BOTTOM_SEL ? reg_m1 : 24'hffffff;
  wire        reg_none = (bp == 3'h0);
  wire        reg_all  = (bp == 3'h7);
  wire        reg_over = ~reg_none & (reg_all | ((tgt_lo <= reg_hi) & (tgt_hi >= reg_lo)));
  wire        reg_in   = ~reg_none & (reg_all | ((tgt_lo >= reg_lo) & (tgt_hi <= reg_hi)));
  wire        bp_hit   = PROTECT_COMPLEMENT ? ~reg_in : reg_over;

  // Individual locks: 16 bottom sectors, 16 top sectors, then 126 blocks
  wire [`FWPE_LOCK_COUNT-1:0] lock_hit;
  wire [`FWPE_LOCK_COUNT-1:0] lock_sel;
  wire lock_one  = frame_end & frame_ok & (opcode == `FWPE_OP_LOCK) & (byte_cnt >= 10'h004);
  wire unlock_one = frame_end & frame_ok & (opcode == `FWPE_OP_UNLOCK) & (byte_cnt >= 10'h004);
  wire write_ok  = frame_end & frame_ok & (bit_cnt == 3'h0) & WRITE_ENABLE_LATCH;
  wire glock     = write_ok & (opcode == `FWPE_OP_GLOCK);
  wire gunlock   = write_ok & (opcode == `FWPE_OP_GUNLOCK);
  genvar i;
  generate
    for (i = 0; i < `FWPE_LOCK_COUNT; i = i + 1) begin : g_lock
      wire [31:0] lo32 = (i < `FWPE_EDGE_SECTORS) ? i * `FWPE_SECTOR_BYTES :
                         (i < 2 * `FWPE_EDGE_SECTORS) ?
                         {8'h00, `FWPE_TOP_BLOCK} + (i - 16) * `FWPE_SECTOR_BYTES :
                         (i - 31) * `FWPE_BLOCK_BYTES;
      wire [31:0] hi32 = lo32 + ((i < 2 * `FWPE_EDGE_SECTORS) ? `FWPE_SECTOR_BYTES - 1 :
                                                               `FWPE_BLOCK_BYTES - 1);
      assign lock_hit[i] = lock[i] & (tgt_lo <= hi32[23:0]) & (tgt_hi >= lo32[23:0]);
      assign lock_sel[i] = (addr >= lo32[23:0]) & (addr <= hi32[23:0]);
      always @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N)
          lock[i] <= 1'b1;
        else if (glock | (write_ok & lock_one & lock_sel[i]))
          lock[i] <= 1'b1;
        else if (gunlock | (write_ok & unlock_one & lock_sel[i]))
          lock[i] <= 1'b0;
      end
    end
  endgenerate

  wire prot_hit  = PROTECT_SCHEME_SEL ? (|lock_hit) : bp_hit;
  wire is_erase  = (opcode == `FWPE_OP_SE) | (opcode == `FWPE_OP_BE32) |
                   (opcode == `FWPE_OP_BE64) | (opcode == `FWPE_OP_CE_A) |
                   (opcode == `FWPE_OP_CE_B);
  wire addr_ok   = (opcode == `FWPE_OP_CE_A) | (opcode == `FWPE_OP_CE_B) |
                   (byte_cnt >= 10'h004);
  wire start_pp  = write_ok & (opcode == `FWPE_OP_PP) & (byte_cnt >= 10'h005) & ~prot_hit;
  wire start_er  = write_ok & is_erase & addr_ok & ~prot_hit;
  wire start_sr  = write_ok & (opcode == `FWPE_OP_STATUS_WRITE_INSTR) & (byte_cnt >= 10'h002);
  wire instr_end = frame_end & frame_ok & (bit_cnt == 3'h0);
  reg  [31:0] er_cycles;
  always @* begin
    case (opcode)
      `FWPE_OP_SE:   er_cycles = SE_CYCLES;
      `FWPE_OP_BE32: er_cycles = BE32_CYCLES;
      `FWPE_OP_BE64: er_cycles = BE64_CYCLES;
      default:       er_cycles = CE_CYCLES;
    endcase
  end

  // Internal cycle engine, latch and power state
  always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state                  <= ST_IDLE;
      cnt                    <= 32'h0;
      pcol                   <= 8'h00;
      page_base              <= 24'h000000;
      WRITE_IN_PROGRESS_FLAG <= 1'b0;
      WRITE_ENABLE_LATCH     <= 1'b0;
      DEEP_SLEEP             <= 1'b0;
      ACTIVE                 <= 1'b0;
      PROG_STROBE            <= 1'b0;
      PROG_ADDR              <= 24'h000000;
      PROG_DATA              <= 8'h00;
      ERASE_STROBE           <= 1'b0;
      ERASE_FIRST            <= 24'h000000;
      ERASE_LAST             <= 24'h000000;
      STATUS_WR_STROBE       <= 1'b0;
      STATUS_WR_DATA         <= 8'h00;
    end else begin
      PROG_STROBE      <= 1'b0;
      ERASE_STROBE     <= 1'b0;
      STATUS_WR_STROBE <= 1'b0;
      ACTIVE <= ~cs_q[1] | WRITE_IN_PROGRESS_FLAG;
      if (instr_end & (opcode == `FWPE_OP_DSLEEP))
        DEEP_SLEEP <= 1'b1;
      if (instr_end & (opcode == `FWPE_OP_DWAKE))
        DEEP_SLEEP <= 1'b0;
      if (instr_end & (opcode == `FWPE_OP_WRITE_ENABLE_INSTR))
        WRITE_ENABLE_LATCH <= 1'b1;
      if (instr_end & (opcode == `FWPE_OP_WRDI))
        WRITE_ENABLE_LATCH <= 1'b0;
      if (glock | gunlock | (write_ok & (lock_one | unlock_one)))
        WRITE_ENABLE_LATCH <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (start_pp) begin
            state     <= ST_PROG;
            cnt       <= PP_CYCLES;
            pcol      <= 8'h00;
            page_base <= {addr[23:8], 8'h00};
            WRITE_IN_PROGRESS_FLAG <= 1'b1;
          end else if (start_er) begin
            state        <= ST_WAIT;
            cnt          <= er_cycles;
            ERASE_STROBE <= 1'b1;
            ERASE_FIRST  <= tgt_lo;
            ERASE_LAST   <= tgt_hi;
            WRITE_IN_PROGRESS_FLAG <= 1'b1;
          end else if (start_sr) begin
            state            <= ST_WAIT;
            cnt              <= SRW_CYCLES;
            STATUS_WR_STROBE <= 1'b1;
            STATUS_WR_DATA   <= sr_data;
            WRITE_IN_PROGRESS_FLAG <= 1'b1;
          end
        end
        ST_PROG: begin
          // Array applies new AND old, so bits only go from 1 to 0
          cnt         <= cnt - 32'h1;
          pcol        <= pcol + 8'h01;
          PROG_STROBE <= page_valid[pcol];
          PROG_ADDR   <= {page_base[23:8], pcol};
          PROG_DATA   <= page_buf[pcol];
          if (pcol == 8'hff)
            state <= ST_WAIT;
        end
        ST_WAIT: begin
          cnt <= cnt - 32'h1;
          if (cnt <= 32'h1) begin
            state                  <= ST_IDLE;
            WRITE_IN_PROGRESS_FLAG <= 1'b0;
            WRITE_ENABLE_LATCH     <= 1'b0;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Status read-back; live flag so a host can poll within one frame
  always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      MISO    <= 1'b0;
      MISO_OE <= 1'b0;
    end else begin
      MISO_OE <= ~cs_q[1] & frame_ok & (opcode == `FWPE_OP_RDSR) & (byte_cnt != 10'h000);
      if (sck_fall & ~cs_q[1])
        MISO <= status[~bit_cnt];
    end
  end
endmodule // fwpe_core
`default_nettype wire

// >>> tb/fwpe_core_asserts.sv
// Port-level checks of the flash protect core
`timescale 1ns/10ps
`default_nettype none
module fwpe_core_asserts (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic CS_N,
  input wire logic WRITE_IN_PROGRESS_FLAG,
  input wire logic WRITE_ENABLE_LATCH,
  input wire logic DEEP_SLEEP,
  input wire logic ACTIVE,
  input wire logic PROG_STROBE,
  input wire logic ERASE_STROBE,
  input wire logic STATUS_WR_STROBE
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  a_erase_sets_busy: assert property (
    ERASE_STROBE |-> ##[0:1] WRITE_IN_PROGRESS_FLAG) else $error("erase start without busy");
  a_wsr_sets_busy: assert property (
    STATUS_WR_STROBE |-> ##[0:1] WRITE_IN_PROGRESS_FLAG) else $error("status write not busy");
  a_prog_in_cycle: assert property (
    PROG_STROBE |-> WRITE_IN_PROGRESS_FLAG) else $error("byte programmed while idle");
  a_busy_holds: assert property (
    $rose(WRITE_IN_PROGRESS_FLAG) |=> WRITE_IN_PROGRESS_FLAG [*8]) else $error("busy too short");
  a_erase_one_pulse: assert property (
    ERASE_STROBE |=> !ERASE_STROBE) else $error("erase strobe longer than one cycle");
  a_wel_clears: assert property (
    $fell(WRITE_IN_PROGRESS_FLAG) |-> ##[0:1] !WRITE_ENABLE_LATCH) else $error("latch kept");
  a_sleep_quiet: assert property (
    DEEP_SLEEP |-> !(ERASE_STROBE || PROG_STROBE || STATUS_WR_STROBE))
    else $error("work started in deep sleep");
  a_sleep_not_busy: assert property (
    $rose(DEEP_SLEEP) |-> !$past(WRITE_IN_PROGRESS_FLAG)) else $error("sleep entered while busy");
  a_select_active: assert property (
    !CS_N [*5] |-> ACTIVE) else $error("selected but not active");
  a_busy_active: assert property (
    WRITE_IN_PROGRESS_FLAG && $past(WRITE_IN_PROGRESS_FLAG) |-> ACTIVE) else $error("busy idle");
  a_idle_standby: assert property (
    (CS_N && !WRITE_IN_PROGRESS_FLAG) [*6] |-> !ACTIVE) else $error("no standby when idle");
endmodule // fwpe_core_asserts
bind fwpe_core fwpe_core_asserts u_chk (.CLK, .RESET_N, .CS_N, .WRITE_IN_PROGRESS_FLAG,
  .WRITE_ENABLE_LATCH, .DEEP_SLEEP, .ACTIVE, .PROG_STROBE, .ERASE_STROBE, .STATUS_WR_STROBE);
`default_nettype wire

// >>> tb/fwpe_host.sv
// Serial host model that frames instructions toward the flash core
`timescale 1ns/10ps
`default_nettype none
module fwpe_host (
  output var logic SCK,
  output var logic CS_N,
  output var logic MOSI
);
  initial begin
    SCK = 1'b0;
    CS_N = 1'b1;
    MOSI = 1'b0;
  end
  // Step off the CLK edges so no link edge races the core's sampling
  task automatic start();
    #1 CS_N = 1'b0;
    #62.5;
  endtask
  task automatic bit_out(input logic b);
    MOSI = b;
    #62.5 SCK = 1'b1;
    #62.5 SCK = 1'b0;
  endtask
  task automatic byte_out(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) bit_out(b[i]);
  endtask
  // Link clock stays low between frames; data line shows no stale value
  task automatic stop();
    #62.5 CS_N = 1'b1;
    MOSI = ~MOSI;
    #100;
  endtask
endmodule // fwpe_host
`default_nettype wire

// >>> tb/flash_write_protect_program_erase_tb.sv
// Self-checking bench for the flash protect core
`timescale 1ns/10ps
`default_nettype none
`include "fwpe_defines.vh"
module flash_write_protect_program_erase_tb;
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        sec, tbs, cmp, protect_scheme_sel;
  logic [2:0]  fld;
  wire         sck, cs_n, mosi, miso, miso_oe, write_in_progress_flag, write_enable_latch, sleep, act, ps, es, ws;
  wire  [23:0] pa, ef, el;
  wire  [7:0]  pd, wd;
  logic [47:0] erq[$];
  logic [31:0] prq[$];
  logic [7:0]  wsq[$];
  logic [31:0] r;
  logic [7:0]  ops[3] = '{`FWPE_OP_SE, `FWPE_OP_BE32, `FWPE_OP_BE64};
  int          szs[3] = '{4096, 32768, 65536};
  int          error_cnt = 0, checked = 0, n, j, lo;
  always #5 clk = ~clk;
  fwpe_host host (.SCK(sck), .CS_N(cs_n), .MOSI(mosi));
  fwpe_core #(.SRW_CYCLES(100), .PP_CYCLES(600), .SE_CYCLES(200), .BE32_CYCLES(200),
    .BE64_CYCLES(200), .CE_CYCLES(300)) dut (.CLK(clk), .RESET_N(reset_n), .SCK(sck),
    .CS_N(cs_n), .MOSI(mosi), .MISO(miso), .MISO_OE(miso_oe), .SECTOR_GRANULARITY_SEL(sec),
    .TOP_BOTTOM_SEL(tbs), .PROTECT_FIELD_BIT2(fld[2]), .PROTECT_FIELD_BIT1(fld[1]),
    .PROTECT_FIELD_BIT0(fld[0]), .PROTECT_COMPLEMENT(cmp), .PROTECT_SCHEME_SEL(protect_scheme_sel),
    .WRITE_IN_PROGRESS_FLAG(write_in_progress_flag), .WRITE_ENABLE_LATCH(write_enable_latch), .DEEP_SLEEP(sleep), .ACTIVE(act),
    .PROG_STROBE(ps), .PROG_ADDR(pa), .PROG_DATA(pd), .ERASE_STROBE(es), .ERASE_FIRST(ef),
    .ERASE_LAST(el), .STATUS_WR_STROBE(ws), .STATUS_WR_DATA(wd));
  always @(posedge clk) begin
    if (es) erq.push_back({ef, el});
    if (ps) prq.push_back({pa, pd});
    if (ws) wsq.push_back(wd);
  end
  // Complemented map: size of the unprotected end region; plain map is its inverse
  function automatic bit prot(input int a);
    int un;
    bit p;
    un = sec ? 4096 << ((fld > 3'd4 ? 4 : fld) - 1) : 16777216 >> (7 - fld);
    p = (fld == 3'd0) || (fld != 3'd7 && (tbs ? a >= un : a < 16777216 - un));
    return cmp ? p : !p;
  endfunction
  task automatic chk(input string w, input logic [47:0] e, input logic [47:0] g);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic ev(input int k);
    repeat (k) @(negedge clk);
  endtask
  // Whole-byte frame: opcode then na bytes of a, high byte first
  task automatic op(input logic [7:0] c, input int na, input logic [23:0] a);
    host.start();
    host.byte_out(c);
    for (int i = 2; i >= 3 - na; i--) host.byte_out(a[8*i +: 8]);
    host.stop();
    ev(8);
  endtask
  task automatic idle();
    int k = 0;
    while (write_in_progress_flag !== 1'b0 && k < 5000) begin
      ev(1);
      k++;
    end
    chk("busy end", 1, k < 5000);
  endtask
  task automatic er(input logic [7:0] c, input int na, input logic [23:0] a, input int sz,
                    input bit ok);
    int m;
    logic [23:0] b, l;
    m = erq.size();
    b = 24'(a & ~(sz - 1));
    l = 24'(b + sz - 1);
    op(`FWPE_OP_WRITE_ENABLE_INSTR, 0, 24'h0);
    op(c, na, a);
    chk("erase taken", ok, erq.size() != m);
    if (ok) begin
      chk("erase range", {b, l}, erq[m]);
      idle();
    end
    chk("latch", !ok, write_enable_latch);
  endtask
  // Status read: opcode, then two status bytes taken while each bit stands
  task automatic rdsr(input logic [7:0] e);
    logic [15:0] s;
    logic        oe;
    s = 16'h0;
    oe = 1'b1;
    host.start();
    host.byte_out(`FWPE_OP_RDSR);
    for (int i = 0; i < 16; i++) begin
      host.bit_out(1'b0);
      s = {s[14:0], miso};
      oe = oe & miso_oe;
    end
    host.stop();
    ev(8);
    chk("status read", {1'b1, e, e}, {oe, s});
  endtask
  task automatic summarize();
    $display("errors %0d checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #600000;
    error_cnt++;
    $display("CHECK FAILED watchdog expected done seen hang");
    summarize();
  end
  initial begin
    {cmp, sec, tbs, fld, protect_scheme_sel} = {1'b1, 2'h0, 3'd7, 1'b0};
    void'($urandom(32'h82775b2b));
    repeat (6) @(negedge clk);
    reset_n = 1'b1;
    ev(4);
    chk("reset state", 4'h0, {write_enable_latch, write_in_progress_flag, sleep, act});
    for (int k = 0; k < 24; k++) begin
      r = $urandom;
      @(negedge clk);
      {cmp, sec, tbs, fld} = r[29:24];
      j = r[31:30] % 3;
      lo = int'(r[23:0]) & ~(szs[j] - 1);
      er(ops[j], 3, r[23:0], szs[j], !(prot(lo) || prot(lo + szs[j] - 1)));
    end
    {cmp, fld, protect_scheme_sel} = {1'b1, 3'd7, 1'b1};
    er(`FWPE_OP_SE, 3, 24'h400000, 4096, 1'b0);
    op(`FWPE_OP_UNLOCK, 3, 24'h400000);
    er(`FWPE_OP_SE, 3, 24'h400123, 4096, 1'b1);
    op(`FWPE_OP_WRITE_ENABLE_INSTR, 0, 24'h0);
    op(`FWPE_OP_LOCK, 3, 24'h400000);
    er(`FWPE_OP_SE, 3, 24'h400000, 4096, 1'b0);
    op(`FWPE_OP_WRITE_ENABLE_INSTR, 0, 24'h0);
    op(`FWPE_OP_GUNLOCK, 0, 24'h0);
    er(`FWPE_OP_BE64, 3, 24'h010000, 65536, 1'b1);
    op(`FWPE_OP_WRITE_ENABLE_INSTR, 0, 24'h0);
    op(`FWPE_OP_GLOCK, 0, 24'h0);
    er(`FWPE_OP_SE, 3, 24'hff1000, 4096, 1'b0);
    {fld, protect_scheme_sel} = {3'd0, 1'b0};
    er(`FWPE_OP_SE, 3, 24'h400000, 4096, 1'b0);
    fld = 3'd7;
    n = erq.size();
    op(`FWPE_OP_WRITE_ENABLE_INSTR, 0, 24'h0);
    host.start();
    host.byte_out(`FWPE_OP_SE);
    for (int i = 0; i < 3; i++) host.byte_out(8'h80 >> (8 * i));
    host.bit_out(1'b0);
    host.stop();
    ev(8);
    chk("partial byte", 0, erq.size() != n);
    n = prq.size();
    op(`FWPE_OP_WRITE_ENABLE_INSTR, 0, 24'h0);
    host.start();
    host.byte_out(`FWPE_OP_PP);
    for (int i = 0; i < 3; i++) host.byte_out(i == 0 ? 8'h80 : i == 2 ? 8'h10 : 8'h00);
    host.byte_out(8'ha5);
    host.byte_out(8'h3c);
    host.stop();
    ev(8);
    rdsr(8'h03);
    op(`FWPE_OP_DSLEEP, 0, 24'h0);
    chk("sleep when busy", 0, sleep);
    idle();
    chk("prog count", 2, prq.size() - n);
    chk("prog byte 0", 32'h800010a5, prq[n]);
    chk("prog byte 1", 32'h8000113c, prq[n+1]);
    chk("latch after prog", 0, write_enable_latch);
    n = wsq.size();
    op(`FWPE_OP_WRITE_ENABLE_INSTR, 0, 24'h0);
    op(`FWPE_OP_STATUS_WRITE_INSTR, 1, 24'h5a0000);
    chk("status busy", 1, write_in_progress_flag);
    idle();
    chk("status byte", 8'h5a, wsq[n]);
    er(`FWPE_OP_CE_A, 0, 24'h0, 16777216, 1'b1);
    er(`FWPE_OP_CE_B, 0, 24'h0, 16777216, 1'b1);
    ev(8);
    chk("standby", 0, act);
    op(`FWPE_OP_DSLEEP, 0, 24'h0);
    chk("sleep", 1, sleep);
    op(`FWPE_OP_WRITE_ENABLE_INSTR, 0, 24'h0);
    chk("ignored in sleep", 0, write_enable_latch);
    op(`FWPE_OP_DWAKE, 0, 24'h0);
    chk("wake", 0, sleep);
    op(`FWPE_OP_WRITE_ENABLE_INSTR, 0, 24'h0);
    rdsr(8'h02);
    op(`FWPE_OP_WRDI, 0, 24'h0);
    rdsr(8'h00);
    summarize();
  end
endmodule // flash_write_protect_program_erase_tb
`default_nettype wire
